/* logic/ptod_defines.svh */
/*
 * bit positions, codes and reset values for the transfer opcode decoder.
 * assumes a 64-bit instruction word with bit 63 as the most significant bit.
 */
`ifndef PTOD_DEFINES_SVH
`define PTOD_DEFINES_SVH

// data-unit field
`define PTOD_DU_HI 63
`define PTOD_DU_LO 38
`define PTOD_B_SEL44 44
`define PTOD_B_SEL43 43
`define PTOD_IMM5_HI 43
`define PTOD_IMM5_LO 39
`define PTOD_MISC_ZERO_HI 58
`define PTOD_MISC_ZERO_LO 45

// transfer field
`define PTOD_LMODE_HI 38
`define PTOD_LMODE_LO 37
`define PTOD_D_HI 36
`define PTOD_D_LO 34
`define PTOD_COND_HI 35
`define PTOD_COND_LO 32
`define PTOD_LSIZE_HI 32
`define PTOD_LSIZE_LO 31
`define PTOD_LSIGN 30
`define PTOD_CSRC 31
`define PTOD_CGLOB 29
`define PTOD_PROT_HI 28
`define PTOD_PROT_LO 25
`define PTOD_LA_HI 29
`define PTOD_LA_LO 27
`define PTOD_LONG 26
`define PTOD_ITM_HI 25
`define PTOD_ITM_LO 24
`define PTOD_BANK_HI 23
`define PTOD_BANK_LO 20
`define PTOD_LLOAD 19
`define PTOD_SUB_HI 18
`define PTOD_SUB_LO 15
`define PTOD_GLOAD 16
`define PTOD_SRC_HI 14
`define PTOD_SRC_LO 12
`define PTOD_SRCBANK_HI 11
`define PTOD_SRCBANK_LO 8
`define PTOD_FSIGN 11
`define PTOD_FSIZE_HI 10
`define PTOD_FSIZE_LO 9
`define PTOD_FDUP 8
`define PTOD_DST_HI 7
`define PTOD_DST_LO 5
`define PTOD_GSEL 4
`define PTOD_LIM_HI 4
`define PTOD_LIM_LO 0
`define PTOD_LONGOFF_HI 14
`define PTOD_LONGOFF_LO 0

// reset values
`define PTOD_RST_WORD 32'h0000_0000
`define PTOD_RST_REG 7'h00

`endif

/* logic/ptod_pkg.sv */
/*
 * types for the transfer opcode decoder.
 * assumes nothing beyond the defines header.
 */
package ptod_pkg;
    typedef enum logic [1:0] {PTOD_SZ_WORD = 2'b00, PTOD_SZ_BYTE = 2'b01, PTOD_SZ_HALF = 2'b10} ptod_size_e;
    typedef enum logic [2:0] {
        PTOD_DU_SIX = 3'b000, PTOD_DU_IMM5 = 3'b001, PTOD_DU_REG = 3'b010,
        PTOD_DU_IMM32 = 3'b011, PTOD_DU_MISC = 3'b100, PTOD_DU_BAD = 3'b111
    } ptod_du_fmt_e;
    typedef enum logic [3:0] {
        PTOD_XF_NONE = 4'h0, PTOD_XF_DUAL = 4'h1, PTOD_XF_MOVE = 4'h2, PTOD_XF_FMOVE = 4'h3,
        PTOD_XF_LLONG = 4'h4, PTOD_XF_GLONG = 4'h5, PTOD_XF_NOND = 4'h6, PTOD_XF_CMOVE = 4'h7,
        PTOD_XF_CFMOVE = 4'h8, PTOD_XF_CGLOB = 4'h9, PTOD_XF_CNOND = 4'ha
    } ptod_xf_fmt_e;
    typedef enum logic [0:0] {PTOD_ST_RUN = 1'b0, PTOD_ST_LWAIT = 1'b1} ptod_state_e;
endpackage : ptod_pkg

/* logic/ptod_field_unit.sv */
/*
 * sub-word extract, extend and replicate of a 32-bit value.
 * assumes item is already limited to the size in use; purely combinational.
 */
`timescale 1ns/10ps
module ptod_field_unit
    import ptod_pkg::*;
(
    input wire logic [31:0] value,
    input wire logic [1:0] size,
    input wire logic [1:0] item,
    input wire logic sign_ext,
    input wire logic replicate,
    output logic [31:0] result
);
    logic [7:0] byte_v;
    logic [15:0] half_v;

    always_comb begin
        byte_v = value[8*item +: 8];
        half_v = item[0] ? value[31:16] : value[15:0];
        case (size)
            PTOD_SZ_BYTE: begin
                if (replicate) begin
                    result = {4{value[7:0]}};
                end else begin
                    result = {{24{sign_ext & byte_v[7]}}, byte_v};
                end
            end
            PTOD_SZ_HALF: begin
                if (replicate) begin
                    result = {2{value[15:0]}};
                end else begin
                    result = {{16{sign_ext & half_v[15]}}, half_v};
                end
            end
            default: result = value;
        endcase
    end
endmodule : ptod_field_unit

/* logic/ptod_decoder.sv */
/*
 * parallel core opcode decoder: data-unit format decode and execution of transfers.
 * assumes src_data, addr_base and gaddr_base hold the registers named by the word in the same
 * cycle, and cond_true is the evaluated condition of the word's condition field.
 */
// Behaviour
// - one 64-bit word yields a data-unit and a transfer operation
// - bits 63 to 38 decode into five data-unit formats
// - bits 38 to 0 decode into ten transfer formats
// - load reads memory at computed address into register, sized, signed, not gated by the condition
// - store writes source register to computed address at chosen size
// - address arithmetic writes effective address to register, no memory access
// - move copies register, optional global routing and condition gate
// - field extract right-aligns byte or halfword, zero or sign extended
// - field replicate fills 32 bits with low byte or halfword
// - sizes byte, halfword, word; word when none given
// - item picks byte 0 to 3 or halfword 0 or 1
// - sign qualifier chooses zero fill or sign extension
// - 5-bit immediate and register src2 formats keep a transfer field
// - 32-bit immediate format takes low bits and has no transfer
// - conditional formats carry condition, source choice and status protect flags
// - load bit set means load, clear means store or address arithmetic
`timescale 1ns/10ps
`include "ptod_defines.svh"
module ptod_decoder
    import ptod_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic [63:0] instr_word,
    input wire logic [31:0] src_data,
    input wire logic [31:0] addr_base,
    input wire logic [31:0] gaddr_base,
    input wire logic cond_true,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_rvalid,
    output logic instr_ready_r,
    output logic illegal_r,
    output logic du_valid_r,
    output ptod_du_fmt_e du_fmt_r,
    output logic [31:0] du_imm_r,
    output logic [3:0] du_protect_r,
    output logic du_csrc_r,
    output ptod_xf_fmt_e xf_fmt_r,
    output logic rf_we_r,
    output logic [6:0] rf_waddr_r,
    output logic [31:0] rf_wdata_r,
    output logic mem_req_r,
    output logic mem_we_r,
    output logic [1:0] mem_size_r,
    output logic [31:0] mem_addr_r,
    output logic [31:0] mem_wdata_r,
    output logic gmem_req_r,
    output logic gmem_we_r,
    output logic [31:0] gmem_addr_r,
    output logic [6:0] gmem_reg_r,
    output logic global_move_r
);
    ptod_state_e state_r, state_nxt;
    logic instr_ready_nxt, illegal_nxt, du_valid_nxt, du_csrc_nxt, rf_we_nxt, mem_req_nxt, mem_we_nxt;
    logic gmem_req_nxt, gmem_we_nxt, global_move_nxt, ld_sign_r, ld_sign_nxt;
    ptod_du_fmt_e du_fmt_nxt;
    ptod_xf_fmt_e xf_fmt_nxt;
    logic [31:0] du_imm_nxt, rf_wdata_nxt, mem_addr_nxt, mem_wdata_nxt, gmem_addr_nxt;
    logic [3:0] du_protect_nxt;
    logic [6:0] rf_waddr_nxt, gmem_reg_nxt, ld_dst_r, ld_dst_nxt, dst_code, d_code, gsrc_code;
    logic [1:0] mem_size_nxt, ld_size_r, ld_size_nxt;
    ptod_du_fmt_e du_fmt;
    ptod_xf_fmt_e xf_fmt;
    logic acc, is_load, is_aa, gate, fu_sign, fu_rep;
    logic [1:0] fu_size, fu_item, lsize;
    logic [31:0] fu_val, fu_res, ea, lim_ofs;
    logic [3:0] sub;

    function automatic ptod_du_fmt_e du_decode(input logic [63:0] w);
        if (w[63:62] == 2'b00 || w[63:61] == 3'b010) begin
            du_decode = PTOD_DU_BAD;
        end else if (w[63:61] == 3'b011) begin
            du_decode = PTOD_DU_SIX;
        end else if (w[63:59] == 5'h11 && w[`PTOD_MISC_ZERO_HI:`PTOD_MISC_ZERO_LO] == 14'h0000) begin
            du_decode = PTOD_DU_MISC;
        end else if (!w[`PTOD_B_SEL44]) begin
            du_decode = PTOD_DU_IMM5;
        end else if (!w[`PTOD_B_SEL43]) begin
            du_decode = PTOD_DU_REG;
        end else begin
            du_decode = PTOD_DU_IMM32;
        end
    endfunction : du_decode

    function automatic logic [1:0] size_of(input logic [1:0] f);
        // word unless byte or half named
        size_of = (f == PTOD_SZ_BYTE || f == PTOD_SZ_HALF) ? f : PTOD_SZ_WORD;
    endfunction : size_of

    function automatic logic [31:0] sext15(input logic [14:0] v);
        sext15 = {{17{v[14]}}, v};
    endfunction : sext15

    ptod_field_unit u_field (
        .value(fu_val),
        .size(fu_size),
        .item(fu_item),
        .sign_ext(fu_sign),
        .replicate(fu_rep),
        .result(fu_res)
    );

    always_comb begin
        du_fmt = du_decode(instr_word);
        sub = instr_word[`PTOD_SUB_HI:`PTOD_SUB_LO];
        dst_code = {instr_word[`PTOD_BANK_HI:`PTOD_BANK_LO], instr_word[`PTOD_DST_HI:`PTOD_DST_LO]};
        d_code = {instr_word[`PTOD_BANK_HI:`PTOD_BANK_LO], instr_word[`PTOD_D_HI:`PTOD_D_LO]};
        gsrc_code = {instr_word[`PTOD_BANK_HI:`PTOD_BANK_LO], instr_word[`PTOD_SRC_HI:`PTOD_SRC_LO]};
        lim_ofs = {{27{instr_word[`PTOD_LIM_HI]}}, instr_word[`PTOD_LIM_HI:`PTOD_LIM_LO]};
        if (du_fmt == PTOD_DU_IMM32 || du_fmt == PTOD_DU_BAD) begin
            xf_fmt = PTOD_XF_NONE;
        end else if (instr_word[`PTOD_LMODE_HI:`PTOD_LMODE_LO] == 2'b00) begin
            if (instr_word[`PTOD_GSEL]) begin
                xf_fmt = PTOD_XF_CGLOB;
            end else if (sub == 4'h0) begin
                xf_fmt = PTOD_XF_CMOVE;
            end else if (sub == 4'h1) begin
                xf_fmt = PTOD_XF_CFMOVE;
            end else if (sub[3:1] == 3'b001) begin
                xf_fmt = PTOD_XF_CNOND;
            end else begin
                xf_fmt = PTOD_XF_GLONG;
            end
        end else if (instr_word[`PTOD_LONG]) begin
            xf_fmt = PTOD_XF_LLONG;
        end else if (sub == 4'h0) begin
            xf_fmt = PTOD_XF_MOVE;
        end else if (sub == 4'h1) begin
            xf_fmt = PTOD_XF_FMOVE;
        end else if (sub[3:1] == 3'b001) begin
            xf_fmt = PTOD_XF_NOND;
        end else begin
            xf_fmt = PTOD_XF_DUAL;
        end
        acc = instr_valid && instr_ready_r;
        gate = (xf_fmt >= PTOD_XF_CMOVE) ? cond_true : 1'b1;
        is_load = instr_word[`PTOD_LLOAD];
        is_aa = !is_load && instr_word[`PTOD_LSIGN];
        lsize = size_of(instr_word[`PTOD_LSIZE_HI:`PTOD_LSIZE_LO]);
        ea = addr_base + ((xf_fmt == PTOD_XF_LLONG) ? sext15(instr_word[`PTOD_LONGOFF_HI:`PTOD_LONGOFF_LO])
                                                    : lim_ofs);
        fu_val = (state_r == PTOD_ST_LWAIT) ? mem_rdata : src_data;
        fu_size = (state_r == PTOD_ST_LWAIT) ? ld_size_r : size_of(instr_word[`PTOD_FSIZE_HI:`PTOD_FSIZE_LO]);
        // item from format or low bits of d field
        fu_item = (xf_fmt == PTOD_XF_CFMOVE) ? instr_word[`PTOD_ITM_HI:`PTOD_ITM_LO] : instr_word[35:34];
        if (fu_size == PTOD_SZ_HALF) begin
            fu_item = {1'b0, fu_item[0]};
        end
        if (state_r == PTOD_ST_LWAIT || fu_size == PTOD_SZ_WORD) begin
            fu_item = 2'b00;
        end
        fu_sign = (state_r == PTOD_ST_LWAIT) ? ld_sign_r : instr_word[`PTOD_FSIGN];
        fu_rep = (state_r == PTOD_ST_RUN) && instr_word[`PTOD_FDUP];

        state_nxt = state_r;
        instr_ready_nxt = instr_ready_r;
        illegal_nxt = 1'b0;
        du_valid_nxt = 1'b0;
        du_fmt_nxt = du_fmt_r;
        du_imm_nxt = du_imm_r;
        du_protect_nxt = du_protect_r;
        du_csrc_nxt = du_csrc_r;
        xf_fmt_nxt = xf_fmt_r;
        rf_we_nxt = 1'b0;
        rf_waddr_nxt = rf_waddr_r;
        rf_wdata_nxt = rf_wdata_r;
        mem_req_nxt = 1'b0;
        mem_we_nxt = 1'b0;
        mem_size_nxt = mem_size_r;
        mem_addr_nxt = mem_addr_r;
        mem_wdata_nxt = mem_wdata_r;
        gmem_req_nxt = 1'b0;
        gmem_we_nxt = 1'b0;
        gmem_addr_nxt = gmem_addr_r;
        gmem_reg_nxt = gmem_reg_r;
        global_move_nxt = 1'b0;
        ld_dst_nxt = ld_dst_r;
        ld_size_nxt = ld_size_r;
        ld_sign_nxt = ld_sign_r;
        case (state_r)
            PTOD_ST_RUN: begin
                if (acc && du_fmt == PTOD_DU_BAD) begin
                    illegal_nxt = 1'b1;
                end else if (acc) begin
                    du_valid_nxt = 1'b1;
                    du_fmt_nxt = du_fmt;
                    xf_fmt_nxt = xf_fmt;
                    du_imm_nxt = (du_fmt == PTOD_DU_IMM32) ? instr_word[31:0]
                                                            : {27'h0, instr_word[`PTOD_IMM5_HI:`PTOD_IMM5_LO]};
                    du_protect_nxt = (xf_fmt >= PTOD_XF_CMOVE) ? instr_word[`PTOD_PROT_HI:`PTOD_PROT_LO] : 4'h0;
                    du_csrc_nxt = (xf_fmt >= PTOD_XF_CMOVE) && instr_word[`PTOD_CSRC];
                    case (xf_fmt)
                        PTOD_XF_MOVE, PTOD_XF_FMOVE, PTOD_XF_CMOVE, PTOD_XF_CFMOVE: begin
                            rf_we_nxt = gate;
                            rf_waddr_nxt = dst_code;
                            rf_wdata_nxt = (xf_fmt == PTOD_XF_MOVE || xf_fmt == PTOD_XF_CMOVE) ? src_data : fu_res;
                            global_move_nxt = gate && (xf_fmt == PTOD_XF_CMOVE) && instr_word[`PTOD_CGLOB];
                        end
                        PTOD_XF_DUAL, PTOD_XF_LLONG: begin
                            if (is_aa) begin
                                rf_we_nxt = 1'b1;
                                rf_waddr_nxt = d_code;
                                rf_wdata_nxt = ea;
                            end else begin
                                mem_req_nxt = 1'b1;
                                mem_we_nxt = !is_load;
                                mem_size_nxt = lsize;
                                mem_addr_nxt = ea;
                                mem_wdata_nxt = src_data;
                                ld_dst_nxt = d_code;
                                ld_size_nxt = lsize;
                                ld_sign_nxt = instr_word[`PTOD_LSIGN];
                                if (is_load) begin
                                    state_nxt = PTOD_ST_LWAIT;
                                    instr_ready_nxt = 1'b0;
                                end
                            end
                            // global half issued in the same cycle
                            if (xf_fmt == PTOD_XF_DUAL) begin
                                gmem_req_nxt = 1'b1;
                                gmem_we_nxt = !instr_word[`PTOD_GLOAD];
                                gmem_addr_nxt = gaddr_base + lim_ofs;
                                gmem_reg_nxt = {4'h0, instr_word[`PTOD_SRC_HI:`PTOD_SRC_LO]};
                            end
                        end
                        PTOD_XF_GLONG, PTOD_XF_CGLOB: begin
                            gmem_req_nxt = gate;
                            gmem_we_nxt = !is_load;
                            gmem_addr_nxt = gaddr_base + sext15(instr_word[`PTOD_LONGOFF_HI:`PTOD_LONGOFF_LO]);
                            gmem_reg_nxt = gsrc_code;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            PTOD_ST_LWAIT: begin
                if (mem_rvalid) begin
                    rf_we_nxt = 1'b1;
                    rf_waddr_nxt = ld_dst_r;
                    rf_wdata_nxt = fu_res;
                    state_nxt = PTOD_ST_RUN;
                    instr_ready_nxt = 1'b1;
                end
            end
            default: state_nxt = PTOD_ST_RUN;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= PTOD_ST_RUN;
            instr_ready_r <= 1'b1;
            illegal_r <= 1'b0;
            du_valid_r <= 1'b0;
            du_fmt_r <= PTOD_DU_SIX;
            du_imm_r <= `PTOD_RST_WORD;
            du_protect_r <= 4'h0;
            du_csrc_r <= 1'b0;
            xf_fmt_r <= PTOD_XF_NONE;
            rf_we_r <= 1'b0;
            rf_waddr_r <= `PTOD_RST_REG;
            rf_wdata_r <= `PTOD_RST_WORD;
            mem_req_r <= 1'b0;
            mem_we_r <= 1'b0;
            mem_size_r <= PTOD_SZ_WORD;
            mem_addr_r <= `PTOD_RST_WORD;
            mem_wdata_r <= `PTOD_RST_WORD;
            gmem_req_r <= 1'b0;
            gmem_we_r <= 1'b0;
            gmem_addr_r <= `PTOD_RST_WORD;
            gmem_reg_r <= `PTOD_RST_REG;
            global_move_r <= 1'b0;
            ld_dst_r <= `PTOD_RST_REG;
            ld_size_r <= PTOD_SZ_WORD;
            ld_sign_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            instr_ready_r <= instr_ready_nxt;
            illegal_r <= illegal_nxt;
            du_valid_r <= du_valid_nxt;
            du_fmt_r <= du_fmt_nxt;
            du_imm_r <= du_imm_nxt;
            du_protect_r <= du_protect_nxt;
            du_csrc_r <= du_csrc_nxt;
            xf_fmt_r <= xf_fmt_nxt;
            rf_we_r <= rf_we_nxt;
            rf_waddr_r <= rf_waddr_nxt;
            rf_wdata_r <= rf_wdata_nxt;
            mem_req_r <= mem_req_nxt;
            mem_we_r <= mem_we_nxt;
            mem_size_r <= mem_size_nxt;
            mem_addr_r <= mem_addr_nxt;
            mem_wdata_r <= mem_wdata_nxt;
            gmem_req_r <= gmem_req_nxt;
            gmem_we_r <= gmem_we_nxt;
            gmem_addr_r <= gmem_addr_nxt;
            gmem_reg_r <= gmem_reg_nxt;
            global_move_r <= global_move_nxt;
            ld_dst_r <= ld_dst_nxt;
            ld_size_r <= ld_size_nxt;
            ld_sign_r <= ld_sign_nxt;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence load_issue_s;
        acc && (xf_fmt == PTOD_XF_DUAL || xf_fmt == PTOD_XF_LLONG) && is_load && !is_aa;
    endsequence
    sequence load_return_s;
        state_r == PTOD_ST_LWAIT && mem_rvalid;
    endsequence

    illegal_no_effect_a: assert property (acc && du_fmt == PTOD_DU_BAD |=>
        illegal_r && !rf_we_r && !mem_req_r && !gmem_req_r && !du_valid_r)
        else $error("illegal word had an effect");
    // data may return in the first wait cycle, so ready then follows it
    load_stalls_a: assert property (load_issue_s |=>
        (mem_req_r && !mem_we_r && !instr_ready_r) ##1 (instr_ready_r == $past(mem_rvalid)))
        else $error("load did not stall");
    load_writeback_a: assert property (load_return_s |=>
        rf_we_r && instr_ready_r && rf_waddr_r == $past(ld_dst_r))
        else $error("load data not written");
    store_data_a: assert property (acc && xf_fmt == PTOD_XF_LLONG && !is_load && !is_aa |=>
        mem_req_r && mem_we_r && mem_wdata_r == $past(src_data))
        else $error("store wrong");
    addr_arith_a: assert property (acc && xf_fmt == PTOD_XF_LLONG && is_aa |=>
        rf_we_r && !mem_req_r && rf_wdata_r == $past(ea))
        else $error("address arithmetic wrong");
    cond_gate_a: assert property (acc && xf_fmt == PTOD_XF_CMOVE && !cond_true && du_fmt != PTOD_DU_BAD |=>
        !rf_we_r)
        else $error("false condition moved");
    replicate_byte_a: assert property (acc && xf_fmt == PTOD_XF_FMOVE && fu_rep && fu_size == PTOD_SZ_BYTE |=>
        rf_wdata_r == {4{$past(src_data[7:0])}})
        else $error("replicate wrong");
    imm32_no_xfer_a: assert property (acc && du_fmt == PTOD_DU_IMM32 |=>
        xf_fmt_r == PTOD_XF_NONE && du_imm_r == $past(instr_word[31:0]) && !mem_req_r)
        else $error("imm32 carried a transfer");
    dual_issue_a: assert property (acc && xf_fmt == PTOD_XF_DUAL && !is_aa |=>
        gmem_req_r && mem_req_r)
        else $error("dual transfer not issued together");
endmodule : ptod_decoder

/* verif/ptod_tb.sv */
/* bench for ptod_decoder: a model of six of the ten transfer kinds is compared with the ports at every result.
   assumes ptod_pkg and the decoder sources are compiled first; no partner model, the bench drives all. */
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
    import ptod_pkg::*;
    logic clock, rst_n, instr_valid, cond_true, mem_rvalid;
    logic [63:0] instr_word, w;
    logic [31:0] src_data, addr_base, gaddr_base, mem_rdata, ev, xv;
    logic instr_ready_r, illegal_r, du_valid_r, du_csrc_r, rf_we_r, mem_req_r, mem_we_r;
    logic gmem_req_r, gmem_we_r, global_move_r;
    ptod_du_fmt_e du_fmt_r;
    ptod_xf_fmt_e xf_fmt_r;
    logic [31:0] du_imm_r, rf_wdata_r, mem_addr_r, mem_wdata_r, gmem_addr_r;
    logic [3:0] du_protect_r;
    logic [6:0] rf_waddr_r, gmem_reg_r;
    logic [1:0] mem_size_r, sz, fs;
    int num_errors = 0, total_checks = 0, n, i, k;
    ptod_du_fmt_e duf [4] = '{PTOD_DU_SIX, PTOD_DU_IMM5, PTOD_DU_REG, PTOD_DU_MISC};
    ptod_xf_fmt_e xff [6] = '{PTOD_XF_MOVE, PTOD_XF_FMOVE, PTOD_XF_LLONG, PTOD_XF_LLONG, PTOD_XF_LLONG,
        PTOD_XF_CMOVE};

    ptod_decoder dut (.*);

    // sub-word fill: size 1 byte, 2 halfword, else whole word
    function automatic logic [31:0] ext(logic [31:0] v, logic [1:0] s, logic sg);
        if (s == 2'h1) return sg ? {{24{v[7]}}, v[7:0]} : {24'h0, v[7:0]};
        if (s == 2'h2) return sg ? {{16{v[15]}}, v[15:0]} : {16'h0, v[15:0]};
        return v;
    endfunction : ext

    function automatic logic [31:0] fld(logic [31:0] v, logic [1:0] s, logic [1:0] it, logic sg, logic rp);
        if (rp) return (s == 2'h1) ? {4{v[7:0]}} : {2{v[15:0]}};
        return ext(v >> ((s == 2'h1 ? 8 : 16) * it), s, sg);
    endfunction : fld

    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : conclude

    // bounded wait for a decode result (wb=0) or a register writeback (wb=1)
    task automatic await(bit wb);
        for (n = 0; n < 4; n++) begin
            #1;
            if ((wb ? rf_we_r : (du_valid_r | illegal_r)) === 1'b1) break;
            @(posedge clock);
        end
        `CHK(n < 4, 1'b1)
    endtask : await

    task automatic issue(logic [63:0] x);
        @(posedge clock);
        instr_valid <= 1'b1;
        instr_word <= x;
        src_data <= $urandom;
        addr_base <= $urandom;
        gaddr_base <= $urandom;
        cond_true <= 1'($urandom);
        @(posedge clock);
        instr_valid <= 1'b0;
        await(1'b0);
    endtask : issue

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    initial begin
        repeat (5000) @(posedge clock);
        num_errors++;
        conclude();
    end

    initial begin
        rst_n = 1'b0;
        instr_valid = 1'b0;
        instr_word = 64'h0;
        {src_data, addr_base, gaddr_base, mem_rdata} = 128'h0;
        cond_true = 1'b0;
        mem_rvalid = 1'b0;
        void'($urandom(44388));
        repeat (10) @(posedge clock);
        `CHK({instr_ready_r, du_valid_r, rf_we_r, mem_req_r, du_fmt_r, xf_fmt_r}, 11'h400)
        rst_n <= 1'b1;
        for (k = 0; k < 3; k++) begin
            w = {$urandom, $urandom};
            w[63:61] = k[2:0];
            issue(w);
            `CHK({illegal_r, du_valid_r, rf_we_r, mem_req_r, gmem_req_r}, 5'h10)
        end
        w = {$urandom, $urandom};
        w[63:62] = 2'h3;
        w[44:43] = 2'h3;
        issue(w);
        `CHK({du_fmt_r, xf_fmt_r}, {PTOD_DU_IMM32, PTOD_XF_NONE})
        `CHK({du_imm_r, rf_we_r, mem_req_r}, {w[31:0], 2'h0})
        for (i = 0; i < 24; i++) begin
            w = {$urandom, $urandom};
            sz = 2'((i / 6) % 3);
            fs = 2'(1 + (i / 6) % 2);
            case (i % 4)
                0: w[63:61] = 3'h3;
                1: w[63:44] = {2'h3, w[61:45], 1'b0};
                2: w[63:43] = {2'h3, w[61:45], 2'h2};
                default: w[63:44] = 20'h88000;
            endcase
            case (i % 6)
                0: {w[38:37], w[30], w[26], w[19:15]} = {2'h1, 7'h0};
                1: {w[38:37], w[35], w[30], w[26], w[19:15], w[10:9]} = {2'h2, fs == 2'h2 ? 1'b0 : w[35], 7'h1, fs};
                5: {w[38:37], w[30], w[18:15], w[4]} = 8'h0;
                default: {w[38:37], w[32:31], w[26], w[19]} = {2'h3, sz, 1'b1, i % 6 == 3};
            endcase
            if (i % 6 == 2) w[30] = 1'b0;
            if (i % 6 == 4) w[30] = 1'b1;
            issue(w);
            ev = addr_base + {{17{w[14]}}, w[14:0]};
            `CHK({du_valid_r, illegal_r}, 2'h2)
            `CHK(du_fmt_r, duf[i % 4])
            `CHK(xf_fmt_r, xff[i % 6])
            if (i % 4 == 1) `CHK(du_imm_r, {27'h0, w[43:39]})
            case (i % 6)
                0: `CHK({rf_we_r, rf_waddr_r, rf_wdata_r}, {1'b1, w[23:20], w[7:5], src_data})
                1: begin
                    xv = fld(src_data, fs, w[35:34], w[11], w[8]);
                    `CHK({rf_we_r, rf_waddr_r, rf_wdata_r}, {1'b1, w[23:20], w[7:5], xv})
                end
                2: `CHK({mem_req_r, mem_we_r, mem_size_r, mem_addr_r, mem_wdata_r}, {2'h3, sz, ev, src_data})
                4: `CHK({rf_we_r, mem_req_r, rf_waddr_r, rf_wdata_r}, {2'h2, w[23:20], w[36:34], ev})
                5: begin
                    `CHK({rf_we_r, global_move_r}, {cond_true, cond_true & w[29]})
                    `CHK({du_protect_r, du_csrc_r}, {w[28:25], w[31]})
                end
                default: begin
                    `CHK({mem_req_r, mem_we_r, instr_ready_r, mem_size_r, mem_addr_r}, {3'h4, sz, ev})
                    @(posedge clock);
                    instr_valid <= 1'b1;
                    instr_word <= 64'h0;
                    k = 0;
                    repeat (1 + i % 3) begin
                        @(posedge clock);
                        #1;
                        k += (illegal_r !== 1'b0);
                    end
                    @(posedge clock);
                    instr_valid <= 1'b0;
                    mem_rvalid <= 1'b1;
                    mem_rdata <= $urandom;
                    @(posedge clock);
                    mem_rvalid <= 1'b0;
                    await(1'b1);
                    `CHK(k == 0, 1'b1)
                    xv = ext(mem_rdata, sz, w[30]);
                    `CHK({rf_we_r, rf_waddr_r, rf_wdata_r}, {1'b1, w[23:20], w[36:34], xv})
                end
            endcase
        end
        // double transfer store, then conditional global transfer
        for (i = 0; i < 2; i++) begin
            w = {$urandom, $urandom};
            w[63:61] = 3'h3;
            if (i == 0) {w[38:37], w[30], w[26], w[19:17]} = 7'h21;
            else {w[38:37], w[4]} = 3'h1;
            issue(w);
            ev = (i == 0) ? {{27{w[4]}}, w[4:0]} : {{17{w[14]}}, w[14:0]};
            xv = (i == 0) ? {29'h0, w[14:12]} : {25'h0, w[23:20], w[14:12]};
            `CHK(xf_fmt_r, i == 0 ? PTOD_XF_DUAL : PTOD_XF_CGLOB)
            `CHK({gmem_req_r, gmem_reg_r}, {i == 0 || cond_true, xv[6:0]})
            `CHK({gmem_we_r, gmem_addr_r}, {!w[i == 0 ? 16 : 19], gaddr_base + ev})
            if (i == 0) `CHK({mem_req_r, mem_we_r, mem_addr_r}, {2'h3, addr_base + ev})
        end
        conclude();
    end
endmodule : tb
